// ### rtl/adcs_cfg.svh
`ifndef ADCS_CFG_SVH
`define ADCS_CFG_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define ADCS_OFS_ACT 8'h00
`define ADCS_OFS_RAW 8'h04
`define ADCS_OFS_MASK 8'h08
`define ADCS_OFS_ISC 8'h0C
`define ADCS_OFS_OVF 8'h10
`define ADCS_OFS_TRIG 8'h14
`define ADCS_OFS_UNF 8'h18
`define ADCS_OFS_PRI 8'h20
`define ADCS_OFS_INIT 8'h28
`define ADCS_OFS_AVG 8'h30
`define ADCS_OFS_SEQ0 8'h40
// ----------------------------------------
// per-sequencer block: 32 bytes each, word index in block
// ----------------------------------------
`define ADCS_SUB_MUX 3'h0
`define ADCS_SUB_CTL 3'h1
`define ADCS_SUB_FIFO 3'h2
`define ADCS_SUB_STAT 3'h3
// ----------------------------------------
// step control nibble bits, reset values, trigger codes
// ----------------------------------------
`define ADCS_CTL_DIFF 0
`define ADCS_CTL_END 1
`define ADCS_CTL_IE 2
`define ADCS_CTL_TEMP 3
`define ADCS_PRI_RESET 16'h3210
`define ADCS_TRIG_SW 4'h0
`define ADCS_TRIG_ALWAYS 4'hF
`endif

// ### rtl/adcs_pkg.sv
package adcs_pkg;
    // sequencer state, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_START = 3'b010,
        ST_WAIT = 3'b100
    } adcs_state_e;
    // request to the analog conversion core
    typedef struct packed {
        logic start;
        logic diff;
        logic temp;
        logic [3:0] chan;
    } adcs_conv_req_s;
    // answer from the analog conversion core
    typedef struct packed {
        logic done;
        logic [9:0] result;
    } adcs_conv_rsp_s;
endpackage

// ### rtl/adcs_sequencer.sv
`timescale 1ns/1ps
`include "adcs_cfg.svh"
// Contract
// - four sequencers, fifos of eight, four, four, one
// - fifo word 32 bits, result low ten
// - each step: input nibble plus control nibble
// - triggers honoured only while active-enable set
// - steps run back-to-back without software help
// - same input may repeat within a sequence
// - raw interrupt after any interrupt-enabled step
// - circular fifo, each read pops oldest
// - status shows head, tail, full, empty
// - overflow and underflow recorded per sequencer
// - control logic runs on converter clock
// - interrupt forwarded only when mask bit set
// - raw status register plus raw-and-mask register
// - write one to masked status clears
// - concurrent triggers served by priority, zero first
// - per-sequencer trigger source select field
// - initiate register bit starts software-triggered sequencer
// - shared averager up to 64, off at reset
// - priority reset gives sequencer zero first
// - differential select n picks inputs 2n, 2n+1
module adcs_sequencer #(
    parameter int NSEQ = 4
) (
    input wire logic REF_CLK_I,
    input wire logic SYS_RST_I,
    input wire logic CE_I,
    input wire logic [7:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    output logic [31:0] AVS_READDATA_O,
    output logic AVS_WAITREQUEST_O,
    input wire logic [3:0] EXT_TRIG_I,
    output adcs_pkg::adcs_conv_req_s CONV_REQ_O,
    input wire adcs_pkg::adcs_conv_rsp_s CONV_RSP_I,
    output logic [3:0] IRQ_O
);
    // ----------------------------------------
    // registers and state
    // ----------------------------------------
    logic ack_reg; // one-cycle bus answer
    logic [31:0] rdata_reg; // read data, captured on request
    logic [3:0] act_reg; // active-enable bits
    logic [3:0] raw_reg; // raw interrupt status
    logic [3:0] mask_reg; // interrupt mask
    logic [3:0] ovf_reg; // fifo overflow flags
    logic [3:0] unf_reg; // fifo underflow flags
    logic [15:0] trig_reg; // trigger source nibbles
    logic [15:0] pri_reg; // priority fields
    logic [2:0] avg_reg; // log2 of averaging count
    logic [31:0] mux_reg [4]; // input select nibbles
    logic [31:0] ctl_reg [4]; // control nibbles
    logic [3:0] pend_reg; // pending triggers
    adcs_pkg::adcs_state_e st_reg;
    logic [1:0] cur_reg; // sequencer in service
    logic [2:0] step_reg; // step in service
    logic [6:0] avg_cnt_reg; // conversions taken for this step
    logic [15:0] acc_reg; // averaging accumulator
    logic [9:0] mem_reg [4][8]; // fifo storage
    logic [2:0] wp_reg [4]; // head: write pointer
    logic [2:0] rp_reg [4]; // tail: read pointer
    logic [3:0] cnt_reg [4]; // fill level
    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    wire req = AVS_READ_I | AVS_WRITE_I;
    wire rd_take = AVS_READ_I & ack_reg;
    wire wr_take = AVS_WRITE_I & ack_reg;
    wire [7:0] adr = AVS_ADDRESS_I;
    wire in_seq = (adr >= `ADCS_OFS_SEQ0) && (adr < 8'hC0);
    wire [2:0] seq_raw = adr[7:5] - 3'h2;
    wire [1:0] aseq = seq_raw[1:0];
    wire [2:0] sub = adr[4:2];
    wire [31:0] wd = AVS_WRITEDATA_I;
    wire wr_isc = wr_take && adr == `ADCS_OFS_ISC;
    wire wr_ovf = wr_take && adr == `ADCS_OFS_OVF;
    wire wr_unf = wr_take && adr == `ADCS_OFS_UNF;
    wire wr_init = wr_take && adr == `ADCS_OFS_INIT;
    wire fifo_rd = rd_take && in_seq && sub == `ADCS_SUB_FIFO;
    // handshake: one wait cycle, then answer
    assign AVS_WAITREQUEST_O = req & ~ack_reg;
    assign AVS_READDATA_O = rdata_reg;
    // ----------------------------------------
    // fifo depth per sequencer
    // ----------------------------------------
    function automatic logic [3:0] depth(input logic [1:0] s);
        depth = (s == 2'd0) ? 4'd8 : (s == 2'd3) ? 4'd1 : 4'd4;
    endfunction
    // ----------------------------------------
    // trigger selection and arbitration
    // ----------------------------------------
    logic [3:0] hit; // trigger events this cycle
    logic [1:0] win; // winning sequencer
    logic win_ok; // some pending sequencer exists
    always_comb begin
        logic [3:0] code;
        logic [1:0] bp;
        code = 4'h0;
        bp = 2'd3;
        win = 2'd0;
        win_ok = 1'b0;
        hit = 4'h0;
        for (int i = 0; i < NSEQ; i++) begin
            code = trig_reg[i*4 +: 4];
            // software, always, or one of four peripheral events
            if (code == `ADCS_TRIG_SW) begin
                hit[i] = wr_init & wd[i];
            end else if (code == `ADCS_TRIG_ALWAYS) begin
                hit[i] = 1'b1;
            end else if (code <= 4'h4) begin
                hit[i] = EXT_TRIG_I[2'(code - 4'h1)];
            end
            hit[i] = hit[i] & act_reg[i];
        end
        // lowest priority value wins; equal values fall to lower index
        for (int i = 0; i < NSEQ; i++) begin
            if (pend_reg[i] && act_reg[i] && (!win_ok || pri_reg[i*4 +: 2] < bp)) begin
                win = 2'(i);
                bp = pri_reg[i*4 +: 2];
                win_ok = 1'b1;
            end
        end
    end
    // ----------------------------------------
    // current step fields
    // ----------------------------------------
    wire [3:0] stp_mux = mux_reg[cur_reg][step_reg*4 +: 4];
    wire [3:0] stp_ctl = ctl_reg[cur_reg][step_reg*4 +: 4];
    wire stp_diff = stp_ctl[`ADCS_CTL_DIFF];
    wire [6:0] avg_last = 7'((8'd1 << avg_reg) - 8'd1);
    wire [15:0] acc_sum = acc_reg + 16'(CONV_RSP_I.result);
    wire conv_done = (st_reg == adcs_pkg::ST_WAIT) && CONV_RSP_I.done;
    wire step_done = conv_done && avg_cnt_reg == avg_last;
    wire [9:0] avg_val = 10'(acc_sum >> avg_reg);
    wire last_step = stp_ctl[`ADCS_CTL_END] || (4'(step_reg) == depth(cur_reg) - 4'd1);
    wire cur_full = cnt_reg[cur_reg] == depth(cur_reg);
    // differential pairs use the even input of pair n as base; one driver for the whole struct
    assign CONV_REQ_O = '{start: st_reg == adcs_pkg::ST_START, diff: stp_diff, temp: stp_ctl[`ADCS_CTL_TEMP],
        chan: stp_diff ? {stp_mux[2:0], 1'b0} : stp_mux};
    assign IRQ_O = raw_reg & mask_reg;
    // ----------------------------------------
    // read multiplexer
    // ----------------------------------------
    logic [31:0] rmux;
    always_comb begin
        rmux = 32'h0000_0000;
        if (in_seq) begin
            unique case (sub)
                `ADCS_SUB_MUX: rmux = mux_reg[aseq];
                `ADCS_SUB_CTL: rmux = ctl_reg[aseq];
                // an empty fifo reads zero: storage has no reset, so a stale slot could show unknowns
                `ADCS_SUB_FIFO: rmux = {22'h00_0000, (cnt_reg[aseq] == 4'd0) ? 10'h000 :
                    mem_reg[aseq][rp_reg[aseq]]};
                `ADCS_SUB_STAT: rmux = {19'h0_0000, cnt_reg[aseq] == depth(aseq), 3'h0,
                    cnt_reg[aseq] == 4'd0, 1'b0, wp_reg[aseq], 1'b0, rp_reg[aseq]};
                default: rmux = 32'h0000_0000;
            endcase
        end else begin
            unique case (adr)
                `ADCS_OFS_ACT: rmux = {28'h000_0000, act_reg};
                `ADCS_OFS_RAW: rmux = {28'h000_0000, raw_reg};
                `ADCS_OFS_MASK: rmux = {28'h000_0000, mask_reg};
                `ADCS_OFS_ISC: rmux = {28'h000_0000, raw_reg & mask_reg};
                `ADCS_OFS_OVF: rmux = {28'h000_0000, ovf_reg};
                `ADCS_OFS_TRIG: rmux = {16'h0000, trig_reg};
                `ADCS_OFS_UNF: rmux = {28'h000_0000, unf_reg};
                `ADCS_OFS_PRI: rmux = {16'h0000, pri_reg};
                `ADCS_OFS_AVG: rmux = {29'h0000_0000, avg_reg};
                default: rmux = 32'h0000_0000; // unmapped and write-only
            endcase
        end
    end
    // ----------------------------------------
    // bus answer and software registers
    // ----------------------------------------
    always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            act_reg <= 4'h0;
            mask_reg <= 4'h0;
            trig_reg <= 16'h0000;
            pri_reg <= `ADCS_PRI_RESET;
            avg_reg <= 3'h0;
            for (int i = 0; i < 4; i++) begin
                mux_reg[i] <= 32'h0000_0000;
                ctl_reg[i] <= 32'h0000_0000;
            end
        end else if (CE_I) begin
            ack_reg <= req & ~ack_reg;
            if (AVS_READ_I && !ack_reg) begin
                rdata_reg <= rmux;
            end
            // plain stores, averaging code 7 held at 6; reserved bits dropped
            if (wr_take) begin
                if (adr == `ADCS_OFS_ACT) act_reg <= wd[3:0];
                if (adr == `ADCS_OFS_MASK) mask_reg <= wd[3:0];
                if (adr == `ADCS_OFS_TRIG) trig_reg <= wd[15:0];
                if (adr == `ADCS_OFS_PRI) pri_reg <= wd[15:0] & 16'h3333;
                if (adr == `ADCS_OFS_AVG) avg_reg <= (wd[2:0] == 3'h7) ? 3'h6 : wd[2:0];
                if (in_seq && sub == `ADCS_SUB_MUX) mux_reg[aseq] <= wd;
                if (in_seq && sub == `ADCS_SUB_CTL) ctl_reg[aseq] <= wd;
            end
        end
    end
    // ----------------------------------------
    // sticky flags: a new event wins over a clear
    // ----------------------------------------
    wire [3:0] irq_set = (step_done && stp_ctl[`ADCS_CTL_IE]) ? (4'h1 << cur_reg) : 4'h0;
    wire [3:0] ovf_set = (step_done && cur_full) ? (4'h1 << cur_reg) : 4'h0;
    wire [3:0] unf_set = (fifo_rd && cnt_reg[aseq] == 4'd0) ? (4'h1 << aseq) : 4'h0;
    always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            raw_reg <= 4'h0;
            ovf_reg <= 4'h0;
            unf_reg <= 4'h0;
            pend_reg <= 4'h0;
        end else if (CE_I) begin
            raw_reg <= (raw_reg & ~(wr_isc ? wd[3:0] : 4'h0)) | irq_set;
            ovf_reg <= (ovf_reg & ~(wr_ovf ? wd[3:0] : 4'h0)) | ovf_set;
            unf_reg <= (unf_reg & ~(wr_unf ? wd[3:0] : 4'h0)) | unf_set;
            // pending drops when taken or disabled; a fresh hit re-arms
            pend_reg <= (pend_reg & act_reg & ~((st_reg == adcs_pkg::ST_IDLE && win_ok) ?
                (4'h1 << win) : 4'h0)) | hit;
        end
    end
    // ----------------------------------------
    // sequence engine, clocked by the converter clock
    // ----------------------------------------
    always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            st_reg <= adcs_pkg::ST_IDLE;
            cur_reg <= 2'd0;
            step_reg <= 3'd0;
            avg_cnt_reg <= 7'd0;
            acc_reg <= 16'h0000;
        end else if (CE_I) begin
            unique case (st_reg)
                adcs_pkg::ST_IDLE: begin
                    if (win_ok) begin
                        cur_reg <= win;
                        step_reg <= 3'd0;
                        st_reg <= adcs_pkg::ST_START;
                    end
                end
                adcs_pkg::ST_START: begin
                    st_reg <= adcs_pkg::ST_WAIT;
                end
                adcs_pkg::ST_WAIT: begin
                    if (conv_done && !step_done) begin
                        // more samples to average for this step
                        acc_reg <= acc_sum;
                        avg_cnt_reg <= avg_cnt_reg + 7'd1;
                        st_reg <= adcs_pkg::ST_START;
                    end else if (step_done) begin
                        acc_reg <= 16'h0000;
                        avg_cnt_reg <= 7'd0;
                        // stop at end mark or last fifo slot, else next step at once
                        if (last_step) begin
                            st_reg <= adcs_pkg::ST_IDLE;
                        end else begin
                            step_reg <= step_reg + 3'd1;
                            st_reg <= adcs_pkg::ST_START;
                        end
                    end
                end
            endcase
        end
    end
    // ----------------------------------------
    // result fifos: circular, pop on read
    // ----------------------------------------
    for (genvar s = 0; s < 4; s++) begin : g_fifo
        wire push = step_done && cur_reg == 2'(s) && !cur_full;
        wire pop = fifo_rd && aseq == 2'(s) && cnt_reg[s] != 4'd0;
        wire [2:0] lim = 3'(depth(2'(s)) - 4'd1);
        always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
            if (SYS_RST_I) begin
                wp_reg[s] <= 3'd0;
                rp_reg[s] <= 3'd0;
                cnt_reg[s] <= 4'd0;
            end else if (CE_I) begin
                if (push) begin
                    mem_reg[s][wp_reg[s]] <= avg_val;
                    wp_reg[s] <= (wp_reg[s] == lim) ? 3'd0 : wp_reg[s] + 3'd1;
                end
                if (pop) begin
                    rp_reg[s] <= (rp_reg[s] == lim) ? 3'd0 : rp_reg[s] + 3'd1;
                end
                cnt_reg[s] <= cnt_reg[s] + 4'(push) - 4'(pop);
            end
        end
    end
    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_irq_mask;
        @(posedge REF_CLK_I) disable iff (SYS_RST_I) (IRQ_O & ~mask_reg) == 4'h0;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("interrupt without mask");
    property p_bus_answer;
        @(posedge REF_CLK_I) disable iff (SYS_RST_I || !CE_I) req && !ack_reg |=> !AVS_WAITREQUEST_O;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");
    property p_pick_active;
        @(posedge REF_CLK_I) disable iff (SYS_RST_I || !CE_I)
            st_reg == adcs_pkg::ST_IDLE && win_ok |=> act_reg[cur_reg] || $past(wr_take);
    endproperty
    a_pick_active: assert property (p_pick_active) else $error("inactive sequencer ran");
    property p_raw_set;
        @(posedge REF_CLK_I) disable iff (SYS_RST_I || !CE_I) irq_set != 4'h0 |=> (raw_reg & $past(irq_set)) != 4'h0;
    endproperty
    a_raw_set: assert property (p_raw_set) else $error("raw interrupt missed");
    property p_isc_clear;
        @(posedge REF_CLK_I) disable iff (SYS_RST_I || !CE_I)
            wr_isc && wd[0] && irq_set[0] == 1'b0 |=> !raw_reg[0];
    endproperty
    a_isc_clear: assert property (p_isc_clear) else $error("clear ignored");
    property p_ovf;
        @(posedge REF_CLK_I) disable iff (SYS_RST_I || !CE_I)
            ovf_set != 4'h0 |=> (ovf_reg & $past(ovf_set)) != 4'h0 && cnt_reg[cur_reg] <= $past(cnt_reg[cur_reg]);
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow mishandled");
    property p_unf;
        @(posedge REF_CLK_I) disable iff (SYS_RST_I || !CE_I) unf_set != 4'h0 |=> (unf_reg & $past(unf_set)) != 4'h0;
    endproperty
    a_unf: assert property (p_unf) else $error("underflow missed");
    property p_end_stop;
        @(posedge REF_CLK_I) disable iff (SYS_RST_I || !CE_I)
            step_done && stp_ctl[`ADCS_CTL_END] |=> st_reg == adcs_pkg::ST_IDLE ##1 1'b1;
    endproperty
    a_end_stop: assert property (p_end_stop) else $error("sequence ran past end");
    property p_next_step;
        @(posedge REF_CLK_I) disable iff (SYS_RST_I || !CE_I)
            step_done && !last_step |=> st_reg == adcs_pkg::ST_START && step_reg == $past(step_reg) + 3'd1;
    endproperty
    a_next_step: assert property (p_next_step) else $error("step not back-to-back");
    property p_fifo_bound;
        @(posedge REF_CLK_I) disable iff (SYS_RST_I) cnt_reg[0] <= 4'd8 && cnt_reg[3] <= 4'd1;
    endproperty
    a_fifo_bound: assert property (p_fifo_bound) else $error("fifo past depth");
endmodule

// ### bench/adcs_conv_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// behavioural analog conversion core
// ----------------------------------------
module adcs_conv_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [2:0] dly_i,
    input wire adcs_pkg::adcs_conv_req_s req_i,
    output adcs_pkg::adcs_conv_rsp_s rsp_o
);
    logic busy_reg; // conversion in flight
    logic [2:0] cnt_reg; // cycles left before done
    logic [9:0] last_reg; // last result handed out
    wire [9:0] res = {3'b101, req_i.temp, req_i.diff, 1'b0, req_i.chan}; // result names its channel
    // answer after a bench-chosen delay; between answers the bus shows the inverse of the last value
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            busy_reg <= 1'b0;
            cnt_reg <= 3'h0;
            last_reg <= 10'h000;
            rsp_o <= '0;
        end else begin
            rsp_o.done <= 1'b0;
            rsp_o.result <= ~last_reg;
            if (req_i.start) begin
                busy_reg <= 1'b1;
                cnt_reg <= dly_i;
            end else if (busy_reg && cnt_reg != 3'h0) begin
                cnt_reg <= cnt_reg - 3'h1;
            end else if (busy_reg) begin
                busy_reg <= 1'b0;
                rsp_o.done <= 1'b1;
                rsp_o.result <= res;
                last_reg <= res;
            end
        end
    end
endmodule

// ### bench/adc_sample_sequencer_tb_top.sv
`timescale 1ns/1ps
`include "adcs_cfg.svh"
module adc_sample_sequencer_tb_top;
    logic clk, rst, rd_en, wr_en, wreq, ce;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, q, mux;
    logic [3:0] ext_trig, irq;
    logic [2:0] dly; // answer delay of the model
    adcs_pkg::adcs_conv_req_s req;
    adcs_pkg::adcs_conv_rsp_s rsp;
    int fail_count = 0, tests_run = 0, seed = 46570, start_cnt = 0, idle = 0, base;
    logic [3:0] starts[$]; // channel of every conversion begun
    adcs_sequencer dut (.REF_CLK_I(clk), .SYS_RST_I(rst), .CE_I(ce), .AVS_ADDRESS_I(addr),
        .AVS_READ_I(rd_en), .AVS_WRITE_I(wr_en), .AVS_WRITEDATA_I(wdata), .AVS_READDATA_O(rdata),
        .AVS_WAITREQUEST_O(wreq), .EXT_TRIG_I(ext_trig), .CONV_REQ_O(req), .CONV_RSP_I(rsp), .IRQ_O(irq));
    adcs_conv_model model (.clk_i(clk), .rst_i(rst), .dly_i(dly), .req_i(req), .rsp_o(rsp));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // log every conversion start
    always @(posedge clk) begin
        if (req.start === 1'b1) begin
            starts.push_back(req.chan);
            start_cnt++;
            idle = 0;
        end else idle++;
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one avalon access; request held until waitrequest is seen low
    task automatic bus(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        addr <= a;
        wdata <= d;
        wr_en <= w;
        rd_en <= !w;
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 50);
        if (wreq !== 1'b0) begin
            chk("bus timeout", 0, 1);
            summarize();
        end
        // answer edge: data taken and request released here, at no other edge
        r = rdata;
        rd_en <= 1'b0;
        wr_en <= 1'b0;
        @(posedge clk); // strobes drop for a cycle between accesses
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    task automatic rdchk(string nm, logic [7:0] a, logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(nm, e, r);
    endtask
    // wait until n conversions began and the link has been quiet a while
    task automatic wait_conv(int n);
        int k;
        for (k = 0; k < 3000 && !(start_cnt >= n && idle > 12); k++) @(posedge clk);
        if (k >= 3000) begin
            chk("conversion timeout", 0, 1);
            summarize();
        end
    endtask
    task automatic pulse(logic [3:0] t);
        dly <= 3'($random(seed));
        ext_trig <= t;
        @(posedge clk);
        ext_trig <= 4'h0;
    endtask
    function automatic logic [7:0] sa(int n, int sub);
        return `ADCS_OFS_SEQ0 + 8'(32 * n + 4 * sub);
    endfunction
    function automatic logic [31:0] exp_res(logic [3:0] ch, logic df);
        return {22'h0, 3'b101, 1'b0, df, 1'b0, ch};
    endfunction
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        addr = 8'h00;
        rd_en = 1'b0;
        wr_en = 1'b0;
        wdata = 32'h0;
        ext_trig = 4'h0;
        dly = 3'h0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rdchk("priority", `ADCS_OFS_PRI, {16'h0, `ADCS_PRI_RESET});
        rdchk("averaging", `ADCS_OFS_AVG, 32'h0);
        rdchk("unmapped", 8'h3C, 32'h0);
        rdchk("fifo0 status", sa(0, 3), 32'h0000_0100);
        // eight-step sequencer: random inputs, end mark on the fifth step
        for (int i = 0; i < 8; i++) mux[i*4+:4] = 4'($random(seed) & 3);
        wr(sa(0, 0), mux);
        wr(sa(0, 1), 32'h0006_0040);
        wr(`ADCS_OFS_TRIG, 32'h0);
        wr(`ADCS_OFS_ACT, 32'h1);
        base = start_cnt;
        wr(`ADCS_OFS_INIT, 32'h1);
        wait_conv(base + 5);
        chk("steps run", base + 5, start_cnt);
        rdchk("fifo0 partial", sa(0, 3), 32'h0000_0050);
        for (int i = 0; i < 5; i++) rdchk("fifo0 word", sa(0, 2), exp_res(mux[i*4+:4], 1'b0));
        rdchk("fifo0 drained", sa(0, 3), 32'h0000_0155);
        rdchk("fifo0 extra", sa(0, 2), 32'h0);
        rdchk("underflow", `ADCS_OFS_UNF, 32'h1);
        rdchk("raw", `ADCS_OFS_RAW, 32'h1);
        chk("irq masked", 4'h0, irq);
        rdchk("masked status", `ADCS_OFS_ISC, 32'h0);
        wr(`ADCS_OFS_MASK, 32'h1);
        chk("irq on", 4'h1, irq);
        wr(`ADCS_OFS_ISC, 32'h0);
        rdchk("raw kept", `ADCS_OFS_RAW, 32'h1);
        wr(`ADCS_OFS_ISC, 32'h1);
        rdchk("raw cleared", `ADCS_OFS_RAW, 32'h0);
        chk("irq off", 4'h0, irq);
        // disabled sequencer ignores its trigger
        wr(`ADCS_OFS_ACT, 32'h0);
        base = start_cnt;
        wr(`ADCS_OFS_INIT, 32'h1);
        repeat (20) @(posedge clk);
        chk("disabled", base, start_cnt);
        // concurrent triggers, sequencer two given the higher priority
        wr(sa(1, 0), 32'h1);
        wr(sa(1, 1), 32'h2);
        wr(sa(2, 0), 32'h2);
        wr(sa(2, 1), 32'h2);
        wr(`ADCS_OFS_TRIG, 32'h0000_0210);
        wr(`ADCS_OFS_PRI, 32'h0000_3012);
        wr(`ADCS_OFS_ACT, 32'h6);
        base = start_cnt;
        pulse(4'h3);
        wait_conv(base + 2);
        chk("first served", 4'h2, starts[base]);
        chk("second served", 4'h1, starts[base+1]);
        rdchk("fifo1 word", sa(1, 2), exp_res(4'h1, 1'b0));
        rdchk("fifo2 word", sa(2, 2), exp_res(4'h2, 1'b0));
        // one-step sequencer, differential pair one, every peripheral trigger
        wr(sa(3, 0), 32'h1);
        wr(sa(3, 1), 32'h3);
        wr(`ADCS_OFS_ACT, 32'h8);
        for (int c = 1; c <= 4; c++) begin
            wr(`ADCS_OFS_TRIG, 32'(c) << 12);
            base = start_cnt;
            pulse(4'h1 << (c - 1));
            wait_conv(base + 1);
            rdchk("fifo3 word", sa(3, 2), exp_res(4'h2, 1'b1));
        end
        // two results into a one-deep fifo
        for (int i = 0; i < 2; i++) begin
            base = start_cnt;
            pulse(4'h8);
            wait_conv(base + 1);
        end
        rdchk("overflow", `ADCS_OFS_OVF, 32'h8);
        bus(1'b0, sa(3, 3), 32'h0, q);
        chk("fifo3 full", 32'h1000, q & 32'h1000);
        rdchk("fifo3 kept", sa(3, 2), exp_res(4'h2, 1'b1));
        // clock enable low: a trigger must leave no trace
        ce <= 1'b0;
        base = start_cnt;
        pulse(4'h8);
        repeat (20) @(posedge clk);
        chk("frozen", base, start_cnt);
        ce <= 1'b1;
        // averaging of four per step
        wr(`ADCS_OFS_AVG, 32'h2);
        wr(`ADCS_OFS_TRIG, 32'h0);
        base = start_cnt;
        wr(`ADCS_OFS_INIT, 32'h8);
        wait_conv(base + 4);
        chk("averaged count", base + 4, start_cnt);
        rdchk("averaged word", sa(3, 2), exp_res(4'h2, 1'b1));
        wr(`ADCS_OFS_AVG, 32'h0);
        // always trigger keeps converting until disabled
        base = start_cnt;
        wr(`ADCS_OFS_TRIG, 32'h0000_F000);
        repeat (100) @(posedge clk);
        wr(`ADCS_OFS_ACT, 32'h0);
        chk("always runs", 1, 32'(start_cnt - base > 3));
        summarize();
    end
endmodule
